//--- prog_model_params.svh
// Constants for the programmer-visible register set.
// Assumes a 12-bit internal address bus and an 8-bit data bus.
`ifndef PROG_MODEL_PARAMS_SVH
`define PROG_MODEL_PARAMS_SVH

`define SP_RESET_VAL 12'h007F
`define SP_FIXED_HI 7'h03
`define SP_LOW_W 5
`define PC_RESET_VAL 12'h0000
`define IO_TOP 12'h000F
`define IO_USED 12'h000B
`define ROM_PAGE0_LO 12'h0080
`define ROM_PAGE0_HI 12'h00FF
`define RAM_LO 12'h0040
`define RAM_HI 12'h007F
`define ROM_MAIN_LO 12'h07C0
`define ROM_MAIN_HI 12'h0F37
`define CHECK_ROM_LO 12'h0F38
`define CHECK_ROM_HI 12'h0FF7
`define VEC_LO 12'h0FF8
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_I 3
`define FLAG_H 4

`endif

//--- prog_model_pkg.sv
// Types for the programmer-visible register set.
// Assumes prog_model_params.svh is compiled alongside.
package prog_model_pkg;

	typedef enum logic [4:0] {
		ST_RUN = 5'b0_0001,
		ST_PUSH_LO = 5'b0_0010,
		ST_PUSH_HI = 5'b0_0100,
		ST_PULL_HI = 5'b0_1000,
		ST_PULL_LO = 5'b1_0000
	} stk_state_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_CALL = 3'h1,
		OP_RET = 3'h2,
		OP_RSP = 3'h3,
		OP_JUMP = 3'h4,
		OP_STEP = 3'h5
	} stk_op_t;

	typedef enum logic [2:0] {
		ALU_NONE = 3'h0,
		ALU_ADD = 3'h1,
		ALU_ADC = 3'h2,
		ALU_SUB = 3'h3,
		ALU_LOGIC = 3'h4,
		ALU_SHIFT = 3'h5,
		ALU_BTB = 3'h6
	} alu_op_t;

	typedef struct packed {
		logic io;
		logic ram;
		logic user_rom;
		logic check_rom;
		logic vector;
	} region_t;

	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] idx;
		logic [11:0] prog_ctr;
		logic [4:0] sp_low;
		logic [4:0] flags_reg;
		logic pend_ext;
		logic pend_second;
		logic pend_timer;
		logic irq_take;
		logic [1:0] ext_sync;
		logic [1:0] sec_sync;
		logic [7:0] in_port_smp;
		logic [7:0] in_port_sync;
		stk_state_t st;
		logic [11:0] ret_addr;
		logic [11:0] bus_addr;
		logic [7:0] bus_wdata;
		logic bus_we;
		logic [11:0] eff_addr;
		region_t region;
		logic [23:0] port_oe;
		logic [23:0] port_out;
		logic [7:0] in_port_val;
	} core_state_t;

endpackage

//--- cpu_prog_model_stack.sv
// Programmer-visible register set, stack engine and address decode.
// Assumes the instruction decoder supplies ops and ALU results and
// on-chip memory answers bus reads in the same cycle.
//
// Summary of operation
// - Program counter is twelve bits wide
// - Reset or reload op sets pointer 07F
// - Push decrements, pull increments stack pointer
// - Upper seven pointer bits fixed 0000011
// - Push low return byte, then high
// - Calls stack only the return address
// - Eight-bit accumulator holds operands and results
// - Indexed address is index plus offset
// - Five-bit flags, four branch-testable
// - Half carry from bit 3 on adds
// - Mask flag blocks timer and external requests
// - Masked requests stay pending until unmasked
// - Negative flag follows result bit 7
// - Zero flag set on zero result
// - Carry from ALU, shifts, bit tests
// - Twelve-bit space, ROM, check ROM, RAM
// - User ROM in three decoded areas
// - Lowest sixteen addresses reserved for I/O; io decode covers only 000-00B
// - Port line direction follows direction bit
// - Input port reads every line's level
// - External request async, reset pin low
`include "prog_model_params.svh"
`timescale 1ns/1ns
`default_nettype none

module cpu_prog_model_stack (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Control from instruction decode
	input wire prog_model_pkg::stk_op_t stk_op,
	input wire logic [11:0] jump_addr,
	input wire logic irq_enter,
	input wire logic [7:0] pull_data,
	input wire logic acc_we,
	input wire logic idx_we,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] instr_offset,
	input wire logic [11:0] decode_addr,
	// Flag update from the ALU
	input wire prog_model_pkg::alu_op_t alu_op,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic alu_carry_out,
	input wire logic [7:0] alu_result,
	input wire logic mask_set,
	input wire logic mask_clr,
	// Interrupt sources
	input wire logic ext_irq_n,
	input wire logic second_ext_irq_n,
	input wire logic timer_irq,
	// Ports
	input wire logic [23:0] port_dir,
	input wire logic [23:0] port_data,
	input wire logic [7:0] in_port_pins,
	// Visible state
	output logic [7:0] acc,
	output logic [7:0] idx,
	output logic [11:0] prog_ctr,
	output logic [11:0] stack_ptr,
	output logic [4:0] flags_reg,
	output logic irq_take,
	output logic stk_busy,
	// Stack memory bus
	output logic [11:0] bus_addr,
	output logic [7:0] bus_wdata,
	output logic bus_we,
	// Decode and ports
	output logic [11:0] eff_addr,
	output prog_model_pkg::region_t region,
	output logic [23:0] port_oe,
	output logic [23:0] port_out,
	output logic [7:0] in_port_val
);

	prog_model_pkg::core_state_t s_r;
	prog_model_pkg::core_state_t s_nxt;

	function automatic logic [11:0] sp_full(input logic [4:0] low);
		sp_full = {`SP_FIXED_HI, low};
	endfunction

	function automatic logic in_rng(input logic [11:0] a,
			input logic [11:0] lo, input logic [11:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [4:0] half;
		logic pend_any;
		s_nxt = s_r;
		half = 5'h00;
		pend_any = 1'b0;
		s_nxt.bus_we = 1'b0;
		s_nxt.irq_take = 1'b0;
		s_nxt.ext_sync = {s_r.ext_sync[0], ~ext_irq_n};
		s_nxt.sec_sync = {s_r.sec_sync[0], ~second_ext_irq_n};
		s_nxt.in_port_sync = in_port_pins;
		s_nxt.in_port_smp = s_r.in_port_sync;
		// input port reads all line levels
		s_nxt.in_port_val = s_r.in_port_smp;
		// latch pending; set wins over service
		if (s_r.ext_sync[1])
			s_nxt.pend_ext = 1'b1;
		if (s_r.sec_sync[1])
			s_nxt.pend_second = 1'b1;
		if (timer_irq)
			s_nxt.pend_timer = 1'b1;
		pend_any = s_r.pend_ext | s_r.pend_second | s_r.pend_timer;
		if (pend_any && !s_r.flags_reg[`FLAG_I] &&
				s_r.st == prog_model_pkg::ST_RUN && !irq_enter) begin
			s_nxt.irq_take = 1'b1;
			if (s_r.pend_ext && !s_r.ext_sync[1])
				s_nxt.pend_ext = 1'b0;
			else if (s_r.pend_second && !s_r.sec_sync[1])
				s_nxt.pend_second = 1'b0;
			else if (!timer_irq)
				s_nxt.pend_timer = 1'b0;
		end
		if (acc_we)
			s_nxt.acc = wr_data;
		if (idx_we)
			s_nxt.idx = wr_data;
		s_nxt.eff_addr = {4'h0, s_r.idx} + {4'h0, instr_offset};
		unique case (alu_op)
			prog_model_pkg::ALU_ADD, prog_model_pkg::ALU_ADC: begin
				// half carry out of bit 3
				half = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} +
					{4'h0, alu_op == prog_model_pkg::ALU_ADC &&
					s_r.flags_reg[`FLAG_C]};
				s_nxt.flags_reg[`FLAG_H] = half[4];
				s_nxt.flags_reg[`FLAG_C] = alu_carry_out;
			end
			prog_model_pkg::ALU_SUB, prog_model_pkg::ALU_SHIFT,
					prog_model_pkg::ALU_BTB:
				s_nxt.flags_reg[`FLAG_C] = alu_carry_out;
			prog_model_pkg::ALU_NONE, prog_model_pkg::ALU_LOGIC: begin
			end
			default: begin
			end
		endcase
		if (alu_op != prog_model_pkg::ALU_NONE &&
				alu_op != prog_model_pkg::ALU_BTB) begin
			s_nxt.flags_reg[`FLAG_N] = alu_result[7];
			s_nxt.flags_reg[`FLAG_Z] = (alu_result == 8'h00);
		end
		if (mask_clr)
			s_nxt.flags_reg[`FLAG_I] = 1'b0;
		if (mask_set)
			s_nxt.flags_reg[`FLAG_I] = 1'b1;
		unique case (s_r.st)
			prog_model_pkg::ST_RUN: begin
				if (irq_enter) begin
					s_nxt.ret_addr = s_r.prog_ctr;
					s_nxt.flags_reg[`FLAG_I] = 1'b1;
					s_nxt.st = prog_model_pkg::ST_PUSH_LO;
				end else begin
					unique case (stk_op)
						prog_model_pkg::OP_CALL: begin
							s_nxt.ret_addr = s_r.prog_ctr;
							s_nxt.st = prog_model_pkg::ST_PUSH_LO;
						end
						prog_model_pkg::OP_RET: begin
							s_nxt.sp_low = s_r.sp_low + 5'd1;
							s_nxt.bus_addr = sp_full(s_r.sp_low + 5'd1);
							s_nxt.st = prog_model_pkg::ST_PULL_HI;
						end
						prog_model_pkg::OP_RSP:
							s_nxt.sp_low = 5'(`SP_RESET_VAL & 12'h01F);
						prog_model_pkg::OP_JUMP:
							s_nxt.prog_ctr = jump_addr;
						prog_model_pkg::OP_STEP:
							s_nxt.prog_ctr = s_r.prog_ctr + 12'd1;
						default: begin
						end
					endcase
				end
			end
			prog_model_pkg::ST_PUSH_LO: begin
				s_nxt.bus_addr = sp_full(s_r.sp_low);
				s_nxt.bus_wdata = s_r.ret_addr[7:0];
				s_nxt.bus_we = 1'b1;
				s_nxt.sp_low = s_r.sp_low - 5'd1;
				s_nxt.st = prog_model_pkg::ST_PUSH_HI;
			end
			prog_model_pkg::ST_PUSH_HI: begin
				s_nxt.bus_addr = sp_full(s_r.sp_low);
				s_nxt.bus_wdata = {4'h0, s_r.ret_addr[11:8]};
				s_nxt.bus_we = 1'b1;
				s_nxt.sp_low = s_r.sp_low - 5'd1;
				s_nxt.prog_ctr = jump_addr;
				s_nxt.st = prog_model_pkg::ST_RUN;
			end
			prog_model_pkg::ST_PULL_HI: begin
				// pull high then increment to low
				s_nxt.prog_ctr[11:8] = pull_data[3:0];
				s_nxt.sp_low = s_r.sp_low + 5'd1;
				s_nxt.bus_addr = sp_full(s_r.sp_low + 5'd1);
				s_nxt.st = prog_model_pkg::ST_PULL_LO;
			end
			prog_model_pkg::ST_PULL_LO: begin
				s_nxt.prog_ctr[7:0] = pull_data;
				s_nxt.st = prog_model_pkg::ST_RUN;
			end
			default:
				s_nxt.st = prog_model_pkg::ST_RUN;
		endcase
		s_nxt.region.io = in_rng(decode_addr, 12'h000, `IO_USED);
		s_nxt.region.ram = in_rng(decode_addr, `RAM_LO, `RAM_HI);
		s_nxt.region.user_rom =
			in_rng(decode_addr, `ROM_PAGE0_LO, `ROM_PAGE0_HI) ||
			in_rng(decode_addr, `ROM_MAIN_LO, `ROM_MAIN_HI) ||
			(decode_addr >= `VEC_LO);
		s_nxt.region.check_rom =
			in_rng(decode_addr, `CHECK_ROM_LO, `CHECK_ROM_HI);
		s_nxt.region.vector = (decode_addr >= `VEC_LO);
		s_nxt.port_oe = port_dir;
		s_nxt.port_out = port_data & port_dir;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s_r <= '0;
			s_r.sp_low <= 5'h1F;
			s_r.prog_ctr <= `PC_RESET_VAL;
			s_r.flags_reg <= 5'h08;
			s_r.st <= prog_model_pkg::ST_RUN;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign acc = s_r.acc;
	assign idx = s_r.idx;
	assign prog_ctr = s_r.prog_ctr;
	assign stack_ptr = sp_full(s_r.sp_low);
	assign flags_reg = s_r.flags_reg;
	assign irq_take = s_r.irq_take;
	assign stk_busy = (s_r.st != prog_model_pkg::ST_RUN);
	assign bus_addr = s_r.bus_addr;
	assign bus_wdata = s_r.bus_wdata;
	assign bus_we = s_r.bus_we;
	assign eff_addr = s_r.eff_addr;
	assign region = s_r.region;
	assign port_oe = s_r.port_oe;
	assign port_out = s_r.port_out;
	assign in_port_val = s_r.in_port_val;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence push_pair;
		bus_we ##1 bus_we;
	endsequence

	a_sp_fixed_hi: assert property (@(posedge core_clk) disable iff (!nrst)
		stack_ptr[11:5] == 7'h03)
		else $error("stack pointer upper bits wrong");

	a_rsp_reload: assert property (@(posedge core_clk) disable iff (!nrst)
		(stk_op == prog_model_pkg::OP_RSP && !irq_enter && !stk_busy)
		|=> stack_ptr == 12'h07F)
		else $error("reload did not set pointer");

	a_call_order: assert property (@(posedge core_clk) disable iff (!nrst)
		(stk_op == prog_model_pkg::OP_CALL && !irq_enter && !stk_busy)
		|=> ##1 push_pair ##0 bus_wdata == {4'h0, $past(prog_ctr[11:8], 3)})
		else $error("call push order wrong");

	a_push_dec: assert property (@(posedge core_clk) disable iff (!nrst)
		bus_we |-> stack_ptr == bus_addr - 12'd1)
		else $error("pointer not decremented on push");

	a_mask_block: assert property (@(posedge core_clk) disable iff (!nrst)
		$past(flags_reg[3]) |-> !irq_take)
		else $error("interrupt taken while masked");

	a_pend_serve: assert property (@(posedge core_clk) disable iff (!nrst)
		(s_r.pend_timer && !flags_reg[3] && !stk_busy && !irq_enter)
		|=> irq_take)
		else $error("pending request not served");

	a_zero_flag: assert property (@(posedge core_clk) disable iff (!nrst)
		(alu_op == prog_model_pkg::ALU_LOGIC && !mask_set && !mask_clr)
		|=> flags_reg[1] == ($past(alu_result) == 8'h00)
		&& flags_reg[2] == $past(alu_result[7]))
		else $error("zero or negative flag wrong");

	a_idx_addr: assert property (@(posedge core_clk) disable iff (!nrst)
		1'b1 |=> eff_addr == {4'h0, $past(idx)} + {4'h0, $past(instr_offset)})
		else $error("indexed address wrong");

	a_dir_gate: assert property (@(posedge core_clk) disable iff (!nrst)
		(port_out & ~port_oe) == 24'h0)
		else $error("undriven line shows data");

endmodule // cpu_prog_model_stack

`default_nettype wire

//--- stack_mem.sv
// Memory partner for the stack bus: a byte array that answers reads
// in the same cycle and takes a write on every rising edge with bus_we high.
`timescale 1ns/1ns
`default_nettype none
module stack_mem (
	// Clock
	input wire logic core_clk,
	// Stack bus
	input wire logic [11:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_we,
	output logic [7:0] pull_data
);
	logic [7:0] mem_r [0:4095];
	// Unwritten bytes hold the inverted low address byte, never a stale push
	initial begin
		for (int i = 0; i < 4096; i++) mem_r[i] = ~i[7:0];
	end
	always @(posedge core_clk) begin
		if (bus_we) mem_r[bus_addr] <= bus_wdata;
	end
	assign pull_data = mem_r[bus_addr];
endmodule // stack_mem
`default_nettype wire

//--- tb.sv
// Self-checking bench for the register set, stack, flags and decode.
// Assumes stack_mem as memory partner and a 50 MHz core clock.
`timescale 1ns/1ns
`default_nettype none
module tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic core_clk = 1'b0, nrst = 1'b0;
	prog_model_pkg::stk_op_t stk_op = prog_model_pkg::OP_NONE;
	prog_model_pkg::alu_op_t alu_op = prog_model_pkg::ALU_NONE;
	prog_model_pkg::region_t region;
	logic [11:0] jump_addr = '0, decode_addr = '0;
	logic irq_enter = 1'b0, acc_we = 1'b0, idx_we = 1'b0;
	logic alu_carry_out = 1'b0, mask_set = 1'b0, mask_clr = 1'b0;
	logic timer_irq = 1'b0, ext_irq_n = 1'b1, second_ext_irq_n = 1'b1;
	logic [7:0] wr_data = '0, instr_offset = '0, alu_a = '0, alu_b = '0;
	logic [7:0] alu_result = '0, in_port_pins = '0, pull_data;
	logic [23:0] port_dir = '0, port_data = '0, port_oe, port_out;
	logic [7:0] acc, idx, bus_wdata, in_port_val;
	logic [11:0] prog_ctr, stack_ptr, bus_addr, eff_addr;
	logic [4:0] flags_reg;
	logic irq_take, stk_busy, bus_we;
	int fail_count = 0, comparisons = 0, cycles = 0;

	cpu_prog_model_stack dut_u (.core_clk, .nrst, .stk_op, .jump_addr,
		.irq_enter, .pull_data, .acc_we, .idx_we, .wr_data, .instr_offset,
		.decode_addr, .alu_op, .alu_a, .alu_b, .alu_carry_out, .alu_result,
		.mask_set, .mask_clr, .ext_irq_n, .second_ext_irq_n, .timer_irq,
		.port_dir, .port_data, .in_port_pins, .acc, .idx, .prog_ctr,
		.stack_ptr, .flags_reg, .irq_take, .stk_busy, .bus_addr,
		.bus_wdata, .bus_we, .eff_addr, .region, .port_oe, .port_out,
		.in_port_val);
	stack_mem mem_u (.core_clk, .bus_addr, .bus_wdata, .bus_we, .pull_data);

	always #10 core_clk = ~core_clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic check(input string what, input logic [23:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		cyc(1);
		while (stk_busy !== 1'b0 && k < 20) begin
			cyc(1);
			k++;
		end
		check("busy", stk_busy, 1'b0);
		cyc(1);
	endtask
	task automatic op(input prog_model_pkg::stk_op_t o);
		stk_op = o;
		cyc(1);
		stk_op = prog_model_pkg::OP_NONE;
		wait_idle();
	endtask
	task automatic alu(input prog_model_pkg::alu_op_t o,
		input logic [7:0] a, b, r, input logic c);
		alu_op = o;
		alu_a = a;
		alu_b = b;
		alu_result = r;
		alu_carry_out = c;
		cyc(1);
		alu_op = prog_model_pkg::ALU_NONE;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		check("sp", stack_ptr, 12'h07F);
		check("pc", prog_ctr, 12'h000);
		check("flags", flags_reg, 5'h08);
	endtask
	task automatic t_call();
		jump_addr = 12'hABC;
		op(prog_model_pkg::OP_JUMP);
		jump_addr = 12'h345;
		op(prog_model_pkg::OP_CALL);
		check("sp", stack_ptr, 12'h07D);
		check("lo", mem_u.mem_r[12'h07F], 8'hBC);
		check("hi", mem_u.mem_r[12'h07E], 8'h0A);
		check("third", mem_u.mem_r[12'h07D], 8'h82);
		check("pc", prog_ctr, 12'h345);
		op(prog_model_pkg::OP_RET);
		check("ret", prog_ctr, 12'hABC);
		check("sp", stack_ptr, 12'h07F);
		// Fifteen nested calls bring the pointer down to 061, one above the lowest pointer 060
		for (int i = 0; i < 15; i++) begin
			jump_addr = 12'(i);
			op(prog_model_pkg::OP_CALL);
		end
		check("deep", stack_ptr, 12'h061);
		check("top", stack_ptr[11:5], 7'h03);
		op(prog_model_pkg::OP_RSP);
		check("rsp", stack_ptr, 12'h07F);
		op(prog_model_pkg::OP_STEP);
		check("step", prog_ctr, 12'h00F);
	endtask
	task automatic t_flags();
		alu(prog_model_pkg::ALU_ADD, 8'h08, 8'h08, 8'h10, 1'b0);
		check("add", {flags_reg[4], flags_reg[2:0]}, 4'h8);
		alu(prog_model_pkg::ALU_ADC, 8'h0F, 8'hF1, 8'h00, 1'b1);
		check("adc", {flags_reg[4], flags_reg[2:0]}, 4'hB);
		alu(prog_model_pkg::ALU_ADD, 8'h01, 8'h02, 8'h03, 1'b0);
		check("addn", {flags_reg[4], flags_reg[2:0]}, 4'h0);
		alu(prog_model_pkg::ALU_SUB, 8'h00, 8'h01, 8'hFF, 1'b1);
		check("sub", flags_reg[2:0], 3'h5);
		alu(prog_model_pkg::ALU_LOGIC, 8'h0F, 8'hF0, 8'h00, 1'b0);
		check("logic", flags_reg[2:1], 2'h1);
		alu(prog_model_pkg::ALU_SHIFT, 8'hC0, 8'h00, 8'h80, 1'b1);
		check("shift", flags_reg[2:0], 3'h5);
		alu(prog_model_pkg::ALU_BTB, 8'h00, 8'h00, 8'h00, 1'b0);
		check("btb", flags_reg[0], 1'b0);
	endtask
	task automatic t_regs();
		acc_we = 1'b1;
		wr_data = 8'h5A;
		cyc(1);
		acc_we = 1'b0;
		idx_we = 1'b1;
		wr_data = 8'hF0;
		instr_offset = 8'h20;
		cyc(1);
		idx_we = 1'b0;
		cyc(2);
		check("acc", acc, 8'h5A);
		check("idx", idx, 8'hF0);
		check("eff", eff_addr, 12'h110);
	endtask
	task automatic t_irq();
		logic hit;
		int k;
		for (int s = 0; s < 3; s++) begin
			hit = 1'b0;
			mask_set = 1'b1;
			ext_irq_n = (s != 0);
			second_ext_irq_n = (s != 1);
			timer_irq = (s == 2);
			cyc(1);
			mask_set = 1'b0;
			repeat (6) begin
				cyc(1);
				hit = hit | irq_take;
			end
			ext_irq_n = 1'b1;
			second_ext_irq_n = 1'b1;
			timer_irq = 1'b0;
			cyc(2);
			check("masked", hit, 1'b0);
			mask_clr = 1'b1;
			cyc(1);
			mask_clr = 1'b0;
			k = 0;
			while (irq_take !== 1'b1 && k < 8) begin
				cyc(1);
				k++;
			end
			check("take", irq_take, 1'b1);
			irq_enter = 1'b1;
			cyc(1);
			irq_enter = 1'b0;
			wait_idle();
			check("imask", flags_reg[3], 1'b1);
			check("isp", stack_ptr, 12'h07D);
			op(prog_model_pkg::OP_RSP);
		end
	endtask
	task automatic t_decode();
		logic [11:0] da [7] = '{12'h000, 12'h040, 12'h080, 12'h0FF,
			12'h7C0, 12'hF37, 12'hF38};
		logic [4:0] dr [7] = '{5'h10, 5'h08, 5'h04, 5'h04, 5'h04, 5'h04, 5'h02};
		for (int i = 0; i < 7; i++) begin
			decode_addr = da[i];
			cyc(2);
			check("region", region, dr[i]);
		end
		decode_addr = 12'hFF8;
		cyc(2);
		check("vector", region.vector, 1'b1);
	endtask
	task automatic t_ports();
		port_dir = 24'hF0_0FA5;
		port_data = 24'h3C_C35A;
		in_port_pins = 8'hA5;
		cyc(4);
		check("oe", port_oe, 24'hF0_0FA5);
		check("out", port_out, 24'h30_0300);
		check("inport", in_port_val, 8'hA5);
	endtask
	task automatic t_reset_again();
		jump_addr = 12'h123;
		op(prog_model_pkg::OP_CALL);
		nrst = 1'b0;
		cyc(3);
		nrst = 1'b1;
		cyc(1);
		check("rpc", prog_ctr, 12'h000);
		check("rsp", stack_ptr, 12'h07F);
	endtask

	initial begin
		cyc(3);
		nrst = 1'b1;
		t_reset();
		t_call();
		t_flags();
		t_regs();
		t_irq();
		t_decode();
		t_ports();
		t_reset_again();
		finish_test();
	end
endmodule // tb
`default_nettype wire
